//--- hw/itc_pkg.sv
package itc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // sizes, reset values and the program counter low byte address
   localparam int PC_W = 11;
   localparam int IW = 16;
   localparam int STACK_DEPTH_DEF = 8;
   localparam int CLKS_PER_ICYCLE = 4;
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   localparam logic [7:0] ACCUM_RESET = 8'h00;
   localparam logic [7:0] PC_LOW_ADDR = 8'h06;

   ////////////////////////////////////////////////////////////////////////////
   // instruction word fields
   localparam int OPC_LSB = 11;
   localparam int BIT_LSB = 8;
   localparam int DEST_BIT = 8;
   localparam int ROT_LEFT_BIT = 8;
   localparam int ROT_CARRY_BIT = 9;
   localparam int ROT_MEM_BIT = 10;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [CLKS_PER_ICYCLE-1:0] {
      PH_1 = 4'h1,
      PH_2 = 4'h2,
      PH_3 = 4'h4,
      PH_4 = 4'h8
   } itc_phase_t;

   typedef enum logic [1:0] {
      ID_NONE = 2'h0,
      ID_HOLD = 2'h1,
      ID_ADV = 2'h2,
      ID_TABLE = 2'h3
   } itc_idle_t;

   typedef enum logic [4:0] {
      OP_MOV_TO_A = 5'h00, OP_MOV_TO_M = 5'h01, OP_MOV_IMM = 5'h02, OP_ADD = 5'h03,
      OP_ADD_IMM = 5'h04, OP_ADDC = 5'h05, OP_SUB = 5'h06, OP_SUB_IMM = 5'h07,
      OP_SUBC = 5'h08, OP_AND = 5'h09, OP_OR = 5'h0a, OP_XOR = 5'h0b,
      OP_AND_IMM = 5'h0c, OP_OR_IMM = 5'h0d, OP_XOR_IMM = 5'h0e, OP_COMPL = 5'h0f,
      OP_INCR = 5'h10, OP_DECR = 5'h11, OP_ROTATE = 5'h12, OP_BIT_CLR = 5'h13,
      OP_BIT_SET = 5'h14, OP_SKIP_ZERO = 5'h15, OP_SKIP_BIT_ZERO = 5'h16, OP_SKIP_BIT_ONE = 5'h17,
      OP_JUMP = 5'h18, OP_CALL = 5'h19, OP_RETURN = 5'h1a, OP_TABLE_RD = 5'h1b,
      OP_HALT = 5'h1c, OP_WDT_CLR = 5'h1d, OP_NOP = 5'h1e, OP_RETURN_IMM = 5'h1f
   } itc_op_t;

endpackage

//--- hw/itc_core.sv
`timescale 1ns/1ps
// How it works
// RQ1 - every instruction cycle is four clocks, fetch in the first and execute in the second.
// RQ2 - most instructions take one instruction cycle, jumps, calls, returns and table reads take two.
// RQ3 - a write to the program counter low byte jumps there and costs one extra cycle.
// RQ4 - a conditional skip costs one cycle if it does not skip and one more if it does.
// RQ5 - and, or, xor and complement set the zero flag when the result is zero.
// RQ6 - rotates move one bit left or right, through-carry forms swap the outgoing bit with carry.
// RQ7 - a call saves the next address and a return resumes there, a jump saves nothing.
// RQ8 - conditional branches test a byte or a bit and run or skip the next instruction.
// RQ9 - bit set and clear change only the chosen bit by an internal read-modify-write.
// RQ10 - increment and decrement add or subtract one, result to memory or accumulator.
// RQ11 - add past 255 and subtract below zero are reported in carry.
// RQ12 - table reads fetch a program memory word and deliver it to data registers.
// RQ13 - moves go memory to accumulator, accumulator to memory and constant to accumulator.
// RQ14 - a halt instruction powers down the core and a dedicated instruction clears the watchdog.
// RQ15 - add and subtract with or without carry update zero, carry, aux carry and overflow.
// RQ16 - an extra cycle is an idle fetch that discards the prefetched word, except after a table read, where the word is written out as data.
module itc_core
   import itc_pkg::*;
#(
   parameter int STACK_DEPTH = STACK_DEPTH_DEF
)
(
   input wire logic clk,
   input wire logic rst_n,
   output logic [PC_W-1:0] prog_addr_ff,
   input wire logic [IW-1:0] prog_data,
   output logic [7:0] dm_addr_ff,
   output logic [7:0] dm_wdata_ff,
   output logic dm_we_ff,
   input wire logic [7:0] dm_rdata,
   input wire logic wake_pin,
   output logic halted_ff,
   output logic wdt_clr_ff,
   output logic [7:0] accum_ff,
   output logic zero_ff,
   output logic carry_ff,
   output logic aux_carry_ff,
   output logic overflow_ff,
   output logic [7:0] table_high_ff
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      return {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
   endfunction

   function automatic logic [7:0] bit_mask(input logic [2:0] idx);
      return 8'h01 << idx;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   itc_phase_t ph_ff, nxt_ph;
   itc_idle_t idle_ff, nxt_idle, pend_ff, nxt_pend;
   logic [IW-1:0] ir_ff, nxt_ir;
   logic [PC_W-1:0] pc_ff, nxt_pc;
   logic [SP_W-1:0] sp_ff, nxt_sp;
   logic [PC_W-1:0] stk_ff [STACK_DEPTH];
   logic [PC_W-1:0] nxt_stk [STACK_DEPTH];
   logic [PC_W-1:0] nxt_prog_addr;
   logic [7:0] nxt_dm_addr, nxt_dm_wdata, nxt_accum, nxt_table_high;
   logic nxt_dm_we, nxt_halted, nxt_wdt_clr, nxt_zero, nxt_carry, nxt_aux_carry, nxt_overflow;
   logic wake_s1_ff, wake_s2_ff;
   itc_op_t op;
   logic exec;

   assign op = itc_op_t'(ir_ff[IW-1:OPC_LSB]);
   assign exec = (idle_ff == ID_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // sequencing and execution
   always_comb
   begin
      logic [7:0] opnd;
      logic [7:0] res;
      logic [10:0] sum;
      logic [2:0] bsel;
      logic [PC_W-1:0] pc_inc;
      logic wr_m;
      logic wr_a;
      logic skip;
      logic arith;
      logic logic_op;
      opnd = 8'h00;
      res = 8'h00;
      sum = 11'h000;
      bsel = ir_ff[BIT_LSB+2:BIT_LSB];
      pc_inc = pc_ff + 11'h001;
      wr_m = 1'b0;
      wr_a = 1'b0;
      skip = 1'b0;
      arith = 1'b0;
      logic_op = 1'b0;
      nxt_ph = ph_ff;
      nxt_idle = idle_ff;
      nxt_pend = pend_ff;
      nxt_ir = ir_ff;
      nxt_pc = pc_ff;
      nxt_sp = sp_ff;
      nxt_stk = stk_ff;
      nxt_prog_addr = prog_addr_ff;
      nxt_dm_addr = dm_addr_ff;
      nxt_dm_wdata = dm_wdata_ff;
      nxt_dm_we = dm_we_ff;
      nxt_halted = halted_ff;
      nxt_wdt_clr = wdt_clr_ff;
      nxt_accum = accum_ff;
      nxt_zero = zero_ff;
      nxt_carry = carry_ff;
      nxt_aux_carry = aux_carry_ff;
      nxt_overflow = overflow_ff;
      nxt_table_high = table_high_ff;
      case (ph_ff)
         PH_1:
         begin
            // the core parks here while powered down
            if (halted_ff)
            begin
               nxt_halted = !wake_s2_ff; // RQ14
            end
            else
            begin
               nxt_ph = PH_2; // RQ1
               if (exec)
               begin
                  nxt_ir = prog_data;
                  nxt_dm_addr = prog_data[7:0];
               end
            end
         end
         PH_2:
         begin
            nxt_ph = PH_3; // RQ1
            if (idle_ff == ID_ADV)
            begin
               nxt_pc = pc_inc; // RQ4
            end
            else if (idle_ff == ID_TABLE)
            begin
               // the program word is still on the bus because the fetch address waits for phase four
               nxt_dm_wdata = prog_data[7:0]; // RQ12
               nxt_dm_we = 1'b1; // RQ12
               nxt_table_high = prog_data[15:8]; // RQ12
            end
            else if (exec)
            begin
               nxt_pc = pc_inc;
               opnd = dm_rdata;
               if (op == OP_MOV_IMM || op == OP_ADD_IMM || op == OP_SUB_IMM || op == OP_AND_IMM ||
                   op == OP_OR_IMM || op == OP_XOR_IMM || op == OP_RETURN_IMM)
               begin
                  opnd = ir_ff[7:0];
               end
               case (op)
                  OP_MOV_TO_A, OP_MOV_IMM:
                  begin
                     res = opnd; // RQ13
                     wr_a = 1'b1;
                  end
                  OP_MOV_TO_M:
                  begin
                     res = accum_ff; // RQ13
                     wr_m = 1'b1;
                  end
                  OP_ADD, OP_ADD_IMM, OP_ADDC:
                  begin
                     sum = add8(accum_ff, opnd, (op == OP_ADDC) && carry_ff); // RQ11
                     arith = 1'b1;
                  end
                  OP_SUB, OP_SUB_IMM, OP_SUBC:
                  begin
                     // carry clear means a borrow happened
                     sum = add8(accum_ff, ~opnd, (op != OP_SUBC) || carry_ff); // RQ11
                     arith = 1'b1;
                  end
                  OP_AND, OP_AND_IMM:
                  begin
                     res = accum_ff & opnd;
                     logic_op = 1'b1;
                  end
                  OP_OR, OP_OR_IMM:
                  begin
                     res = accum_ff | opnd;
                     logic_op = 1'b1;
                  end
                  OP_XOR, OP_XOR_IMM:
                  begin
                     res = accum_ff ^ opnd;
                     logic_op = 1'b1;
                  end
                  OP_COMPL:
                  begin
                     res = ~opnd;
                     logic_op = 1'b1;
                  end
                  OP_INCR, OP_DECR:
                  begin
                     res = (op == OP_INCR) ? opnd + 8'h01 : opnd - 8'h01; // RQ10
                     nxt_zero = (res == 8'h00);
                     wr_m = ir_ff[DEST_BIT]; // RQ10
                     wr_a = !ir_ff[DEST_BIT]; // RQ10
                  end
                  OP_ROTATE:
                  begin
                     if (ir_ff[ROT_LEFT_BIT])
                     begin
                        res = {opnd[6:0], ir_ff[ROT_CARRY_BIT] ? carry_ff : opnd[7]}; // RQ6
                        nxt_carry = ir_ff[ROT_CARRY_BIT] ? opnd[7] : carry_ff; // RQ6
                     end
                     else
                     begin
                        res = {ir_ff[ROT_CARRY_BIT] ? carry_ff : opnd[0], opnd[7:1]}; // RQ6
                        nxt_carry = ir_ff[ROT_CARRY_BIT] ? opnd[0] : carry_ff; // RQ6
                     end
                     wr_m = ir_ff[ROT_MEM_BIT];
                     wr_a = !ir_ff[ROT_MEM_BIT];
                  end
                  OP_BIT_CLR:
                  begin
                     res = opnd & ~bit_mask(bsel); // RQ9
                     wr_m = 1'b1;
                  end
                  OP_BIT_SET:
                  begin
                     res = opnd | bit_mask(bsel); // RQ9
                     wr_m = 1'b1;
                  end
                  OP_SKIP_ZERO:
                  begin
                     // the dest bit here asks for a copy into the accumulator
                     res = opnd;
                     wr_a = ir_ff[DEST_BIT];
                     skip = (opnd == 8'h00); // RQ8
                  end
                  OP_SKIP_BIT_ZERO:
                  begin
                     skip = !opnd[bsel]; // RQ8
                  end
                  OP_SKIP_BIT_ONE:
                  begin
                     skip = opnd[bsel]; // RQ8
                  end
                  OP_JUMP:
                  begin
                     nxt_pc = ir_ff[PC_W-1:0]; // RQ7
                     nxt_pend = ID_HOLD; // RQ2
                  end
                  OP_CALL:
                  begin
                     // deeper nesting than the stack silently overwrites the oldest entry
                     nxt_stk[sp_ff] = pc_inc; // RQ7
                     nxt_sp = sp_ff + 1'b1;
                     nxt_pc = ir_ff[PC_W-1:0];
                     nxt_pend = ID_HOLD; // RQ2
                  end
                  OP_RETURN, OP_RETURN_IMM:
                  begin
                     nxt_sp = sp_ff - 1'b1;
                     nxt_pc = stk_ff[sp_ff - 1'b1]; // RQ7
                     nxt_pend = ID_HOLD; // RQ2
                     res = opnd;
                     wr_a = (op == OP_RETURN_IMM);
                  end
                  OP_TABLE_RD:
                  begin
                     nxt_pend = ID_TABLE; // RQ2
                  end
                  OP_HALT:
                  begin
                     nxt_halted = 1'b1; // RQ14
                  end
                  OP_WDT_CLR:
                  begin
                     nxt_wdt_clr = 1'b1; // RQ14
                  end
                  default:
                  begin
                     res = 8'h00;
                  end
               endcase
               if (arith)
               begin
                  res = sum[7:0];
                  nxt_overflow = sum[10]; // RQ15
                  nxt_aux_carry = sum[9]; // RQ15
                  nxt_carry = sum[8]; // RQ11
                  nxt_zero = (sum[7:0] == 8'h00); // RQ15
                  wr_m = (op != OP_ADD_IMM) && (op != OP_SUB_IMM) && ir_ff[DEST_BIT];
                  wr_a = !wr_m;
               end
               if (logic_op)
               begin
                  nxt_zero = (res == 8'h00); // RQ5
                  wr_m = (op == OP_COMPL || op == OP_AND || op == OP_OR || op == OP_XOR) && ir_ff[DEST_BIT];
                  wr_a = !wr_m;
               end
               if (wr_a)
               begin
                  nxt_accum = res;
               end
               if (wr_m)
               begin
                  nxt_dm_wdata = res;
                  nxt_dm_we = 1'b1;
                  if (dm_addr_ff == PC_LOW_ADDR)
                  begin
                     nxt_pc = {pc_ff[PC_W-1:8], res}; // RQ3
                     nxt_pend = ID_HOLD; // RQ3
                  end
               end
               if (skip)
               begin
                  nxt_pend = ID_ADV; // RQ4
               end
            end
         end
         PH_3:
         begin
            nxt_ph = PH_4; // RQ1
            nxt_dm_we = 1'b0;
            nxt_wdt_clr = 1'b0;
         end
         PH_4:
         begin
            nxt_ph = PH_1; // RQ1
            // a pending extra cycle turns the next cycle idle, so the word it fetches is not executed; after a table read it is kept as data
            nxt_idle = pend_ff; // RQ16
            nxt_pend = ID_NONE;
            nxt_prog_addr = (pend_ff == ID_TABLE) ? {{(PC_W-8){1'b0}}, accum_ff} : pc_ff; // RQ12
         end
         default:
         begin
            nxt_ph = PH_1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ph_ff <= PH_1;
         idle_ff <= ID_NONE;
         pend_ff <= ID_NONE;
         ir_ff <= 16'h0000;
         pc_ff <= PC_RESET;
         sp_ff <= '0;
         for (int i = 0; i < STACK_DEPTH; i++)
         begin
            stk_ff[i] <= PC_RESET;
         end
         prog_addr_ff <= PC_RESET;
         dm_addr_ff <= 8'h00;
         dm_wdata_ff <= 8'h00;
         dm_we_ff <= 1'b0;
         halted_ff <= 1'b0;
         wdt_clr_ff <= 1'b0;
         accum_ff <= ACCUM_RESET;
         zero_ff <= 1'b0;
         carry_ff <= 1'b0;
         aux_carry_ff <= 1'b0;
         overflow_ff <= 1'b0;
         table_high_ff <= 8'h00;
         wake_s1_ff <= 1'b0;
         wake_s2_ff <= 1'b0;
      end
      else
      begin
         ph_ff <= nxt_ph;
         idle_ff <= nxt_idle;
         pend_ff <= nxt_pend;
         ir_ff <= nxt_ir;
         pc_ff <= nxt_pc;
         sp_ff <= nxt_sp;
         stk_ff <= nxt_stk;
         prog_addr_ff <= nxt_prog_addr;
         dm_addr_ff <= nxt_dm_addr;
         dm_wdata_ff <= nxt_dm_wdata;
         dm_we_ff <= nxt_dm_we;
         halted_ff <= nxt_halted;
         wdt_clr_ff <= nxt_wdt_clr;
         accum_ff <= nxt_accum;
         zero_ff <= nxt_zero;
         carry_ff <= nxt_carry;
         aux_carry_ff <= nxt_aux_carry;
         overflow_ff <= nxt_overflow;
         table_high_ff <= nxt_table_high;
         wake_s1_ff <= wake_pin;
         wake_s2_ff <= wake_s1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_ICYCLE_FOUR: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
      (ph_ff == PH_1 && !halted_ff) |=> ph_ff == PH_2 ##1 ph_ff == PH_3 ##1 ph_ff == PH_4 ##1 ph_ff == PH_1)
      else $error("instruction cycle is not four clocks");
   AST_JUMP_TWO: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
      (ph_ff == PH_2 && exec && op == OP_JUMP) |-> ##3 (idle_ff == ID_HOLD && prog_addr_ff == ir_ff[PC_W-1:0]))
      else $error("jump did not take an idle second cycle at its target");
   AST_LOW_BYTE_JUMP: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
      (ph_ff == PH_2 && exec && nxt_dm_we && dm_addr_ff == PC_LOW_ADDR)
      |=> (pc_ff[7:0] == dm_wdata_ff) ##2 (idle_ff == ID_HOLD))
      else $error("low byte write did not jump");
   AST_SKIP_EXTRA: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
      (ph_ff == PH_2 && exec && op == OP_SKIP_ZERO && dm_rdata == 8'h00) |-> ##3 (idle_ff == ID_ADV))
      else $error("taken skip did not add a cycle");
   AST_BIT_NO_SKIP: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
      (ph_ff == PH_2 && exec && op == OP_SKIP_BIT_ONE && !dm_rdata[ir_ff[BIT_LSB+2:BIT_LSB]])
      |-> ##3 (idle_ff == ID_NONE))
      else $error("untaken bit test skipped");
   AST_LOGIC_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
      (ph_ff == PH_2 && exec && op == OP_AND && (accum_ff & dm_rdata) == 8'h00) |=> zero_ff)
      else $error("zero flag missed on logic result");
   AST_ROTATE_LEFT: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
      (ph_ff == PH_2 && exec && op == OP_ROTATE && ir_ff[ROT_MEM_BIT:ROT_LEFT_BIT] == 3'h1)
      |=> accum_ff == (($past(dm_rdata) << 1) | ($past(dm_rdata) >> 7)))
      else $error("plain left rotate wrong");
   AST_CALL_SAVES: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
      (ph_ff == PH_2 && exec && op == OP_CALL)
      |=> (sp_ff == $past(sp_ff) + 1'b1) && (stk_ff[$past(sp_ff)] == $past(pc_ff) + 11'h001))
      else $error("call did not save the next address");
   AST_BIT_SET: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
      (ph_ff == PH_2 && exec && op == OP_BIT_SET)
      |=> dm_we_ff && dm_wdata_ff == ($past(dm_rdata) | bit_mask(ir_ff[BIT_LSB+2:BIT_LSB])))
      else $error("bit set touched other bits");
   AST_ADD_CARRY: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
      (ph_ff == PH_2 && exec && op == OP_ADD && ({1'b0, accum_ff} + {1'b0, dm_rdata}) > 9'h0ff) |=> carry_ff)
      else $error("carry missed on add overflow");
   AST_HALT: assert property (@(posedge clk) disable iff (!rst_n) // RQ14
      (ph_ff == PH_2 && exec && op == OP_HALT) |=> halted_ff ##1 !dm_we_ff)
      else $error("halt did not power down");
   AST_IDLE_DISCARD: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
      (ph_ff == PH_2 && idle_ff == ID_HOLD) |=> !dm_we_ff && pc_ff == $past(pc_ff) && ir_ff == $past(ir_ff))
      else $error("idle cycle executed the discarded word");

endmodule

//--- dv/itc_mem_model.sv
`timescale 1ns/1ps
// program and data memory seen by the core; reads are combinational, so no wait states
module itc_mem_model
   import itc_pkg::*;
(
   input wire logic clk,
   input wire logic [PC_W-1:0] prog_addr,
   output logic [IW-1:0] prog_data,
   input wire logic [7:0] dm_addr,
   input wire logic [7:0] dm_wdata,
   input wire logic dm_we,
   output logic [7:0] dm_rdata
);
   logic [IW-1:0] prog_mem [0:(1<<PC_W)-1];
   logic [7:0] data_mem [0:255];

   assign prog_data = prog_mem[prog_addr];
   assign dm_rdata = data_mem[dm_addr];

   // write lands at the edge ending the strobe cycle
   always @(posedge clk)
   begin
      if (dm_we === 1'b1)
         data_mem[dm_addr] <= dm_wdata;
   end
endmodule

//--- dv/instruction_timing_control_test.sv
`timescale 1ns/1ps
module instruction_timing_control_test
   import itc_pkg::*;
;
   logic clk, rst_n, wake_pin, dm_we_ff, halted_ff, wdt_clr_ff;
   logic zero_ff, carry_ff, aux_carry_ff, overflow_ff;
   logic [PC_W-1:0] prog_addr_ff;
   logic [IW-1:0] prog_data;
   logic [7:0] dm_addr_ff, dm_wdata_ff, dm_rdata, accum_ff, table_high_ff;
   int miscompares = 0;
   int check_count = 0;
   int wdt_n = 0;

   itc_core #(.STACK_DEPTH(8)) i_dut (.clk(clk), .rst_n(rst_n), .prog_addr_ff(prog_addr_ff),
      .prog_data(prog_data), .dm_addr_ff(dm_addr_ff), .dm_wdata_ff(dm_wdata_ff), .dm_we_ff(dm_we_ff),
      .dm_rdata(dm_rdata), .wake_pin(wake_pin), .halted_ff(halted_ff), .wdt_clr_ff(wdt_clr_ff),
      .accum_ff(accum_ff), .zero_ff(zero_ff), .carry_ff(carry_ff), .aux_carry_ff(aux_carry_ff),
      .overflow_ff(overflow_ff), .table_high_ff(table_high_ff));

   itc_mem_model i_mem (.clk(clk), .prog_addr(prog_addr_ff), .prog_data(prog_data), .dm_addr(dm_addr_ff),
      .dm_wdata(dm_wdata_ff), .dm_we(dm_we_ff), .dm_rdata(dm_rdata));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (wdt_clr_ff === 1'b1)
         wdt_n <= wdt_n + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic pm(input int a, input itc_op_t op, input logic [2:0] v, input logic [7:0] imm);
      i_mem.prog_mem[a] = {op, v, imm};
   endtask

   // blank memories, then a fresh reset so every program starts at address 0
   task automatic clear_mem();
      rst_n = 1'b0;
      wake_pin = 1'b0;
      for (int i = 0; i < (1<<PC_W); i++)
         i_mem.prog_mem[i] = {OP_NOP, 11'h000};
      for (int i = 0; i < 256; i++)
         i_mem.data_mem[i] = 8'h00;
   endtask

   task automatic start();
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
   endtask

   // counts edges until the fetch address reaches tgt; a negative count skips the timing check
   task automatic go(input logic [10:0] tgt, input int exp_n);
      int n;
      n = 0;
      while (prog_addr_ff !== tgt && n < 300)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      // a fetch address that never arrives is a hang, counted even when timing is not checked
      if (n >= 300)
         miscompares++;
      if (exp_n >= 0)
         chk(8'(n), 8'(exp_n));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_call_return();
      clear_mem();
      pm(0, OP_CALL, 3'h0, 8'h08);
      pm(1, OP_MOV_IMM, 3'h0, 8'h11);
      pm(2, OP_JUMP, 3'h0, 8'h04);
      pm(3, OP_MOV_IMM, 3'h0, 8'haa);
      pm(4, OP_MOV_IMM, 3'h0, 8'h22);
      pm(5, OP_CALL, 3'h0, 8'h09);
      pm(6, OP_JUMP, 3'h0, 8'h06);
      pm(8, OP_RETURN, 3'h0, 8'h00);
      pm(9, OP_RETURN_IMM, 3'h0, 8'h5c);
      start();
      go(11'h002, 20);
      chk(accum_ff, 8'h11);
      go(11'h005, 12);
      chk(accum_ff, 8'h22);
      go(11'h006, 12);
      chk(accum_ff, 8'h5c);
   endtask

   task automatic t_skips();
      clear_mem();
      i_mem.data_mem[8'h11] = 8'h05;
      pm(0, OP_SKIP_BIT_ONE, 3'h2, 8'h11);
      pm(1, OP_OR_IMM, 3'h0, 8'h01);
      pm(2, OP_SKIP_BIT_ZERO, 3'h1, 8'h11);
      pm(3, OP_OR_IMM, 3'h0, 8'h02);
      pm(4, OP_SKIP_ZERO, 3'h0, 8'h11);
      pm(5, OP_SKIP_ZERO, 3'h1, 8'h10);
      pm(6, OP_OR_IMM, 3'h0, 8'h04);
      pm(7, OP_OR_IMM, 3'h0, 8'h80);
      pm(8, OP_SKIP_BIT_ONE, 3'h1, 8'h11);
      pm(9, OP_OR_IMM, 3'h0, 8'h01);
      pm(10, OP_JUMP, 3'h0, 8'h0a);
      start();
      go(11'h008, 32);
      chk(accum_ff, 8'h80);
      go(11'h00a, 8);
      chk(accum_ff, 8'h81);
   endtask

   task automatic t_pc_low();
      clear_mem();
      pm(0, OP_MOV_IMM, 3'h0, 8'h05);
      pm(1, OP_MOV_TO_M, 3'h0, PC_LOW_ADDR);
      pm(2, OP_MOV_IMM, 3'h0, 8'haa);
      pm(5, OP_MOV_IMM, 3'h0, 8'h33);
      pm(6, OP_MOV_IMM, 3'h0, 8'hfd);
      pm(7, OP_ADD, 3'h0, PC_LOW_ADDR);
      pm(8, OP_ADDC, 3'h0, PC_LOW_ADDR);
      pm(9, OP_SUBC, 3'h0, PC_LOW_ADDR);
      pm(10, OP_SUB, 3'h0, PC_LOW_ADDR);
      pm(11, OP_OR, 3'h1, 8'h30);
      pm(12, OP_JUMP, 3'h0, 8'h0c);
      start();
      go(11'h006, 16);
      chk(accum_ff, 8'h33);
      chk(i_mem.data_mem[PC_LOW_ADDR], 8'h05);
      go(11'h008, 8);
      chk({carry_ff, accum_ff[6:0]}, 8'h82);
      go(11'h009, 4);
      chk({carry_ff, accum_ff[6:0]}, 8'h08);
      go(11'h00a, 4);
      chk({carry_ff, aux_carry_ff, accum_ff[5:0]}, 8'hc2);
      go(11'h00b, 4);
      chk({carry_ff, accum_ff[6:0]}, 8'h7d);
      go(11'h00c, 4);
      chk(i_mem.data_mem[8'h30], 8'hfd);
   endtask

   task automatic t_datapath();
      clear_mem();
      i_mem.data_mem[8'h20] = 8'hf0;
      i_mem.data_mem[8'h21] = 8'h81;
      i_mem.data_mem[8'h22] = 8'h5a;
      i_mem.prog_mem[8'h40] = 16'hbeef;
      pm(0, OP_MOV_IMM, 3'h0, 8'h0f);
      pm(1, OP_AND, 3'h0, 8'h20);
      pm(2, OP_OR_IMM, 3'h0, 8'h3c);
      pm(3, OP_XOR_IMM, 3'h0, 8'h3c);
      pm(4, OP_COMPL, 3'h1, 8'h20);
      pm(5, OP_MOV_IMM, 3'h0, 8'hff);
      pm(6, OP_ADD_IMM, 3'h0, 8'h01);
      pm(7, OP_SUB_IMM, 3'h0, 8'h01);
      pm(8, OP_MOV_IMM, 3'h0, 8'h7f);
      pm(9, OP_ADD_IMM, 3'h0, 8'h01);
      pm(10, OP_ROTATE, 3'h1, 8'h21);
      pm(11, OP_ROTATE, 3'h2, 8'h21);
      pm(12, OP_ROTATE, 3'h7, 8'h21);
      pm(13, OP_ROTATE, 3'h0, 8'h21);
      pm(14, OP_INCR, 3'h0, 8'h21);
      pm(15, OP_DECR, 3'h1, 8'h21);
      pm(16, OP_BIT_SET, 3'h0, 8'h22);
      pm(17, OP_BIT_CLR, 3'h6, 8'h22);
      pm(18, OP_MOV_TO_A, 3'h0, 8'h22);
      pm(19, OP_MOV_TO_M, 3'h0, 8'h23);
      pm(20, OP_MOV_IMM, 3'h0, 8'h40);
      pm(21, OP_TABLE_RD, 3'h0, 8'h24);
      pm(22, OP_WDT_CLR, 3'h0, 8'h00);
      pm(23, OP_HALT, 3'h0, 8'h00);
      pm(24, OP_MOV_IMM, 3'h0, 8'h77);
      pm(25, OP_JUMP, 3'h0, 8'h19);
      start();
      go(11'h002, 8);
      chk({zero_ff, accum_ff[6:0]}, 8'h80);
      go(11'h003, 4);
      chk({zero_ff, accum_ff[6:0]}, 8'h3c);
      go(11'h004, 4);
      chk({7'h0, zero_ff}, 8'h01);
      go(11'h005, 4);
      chk(i_mem.data_mem[8'h20], 8'h0f);
      chk({7'h0, zero_ff}, 8'h00);
      go(11'h007, 8);
      chk({4'h0, zero_ff, carry_ff, aux_carry_ff, overflow_ff}, 8'h0e);
      go(11'h008, 4);
      chk({zero_ff, carry_ff, accum_ff[5:0]}, 8'h3f);
      go(11'h00a, 8);
      chk({5'h0, carry_ff, aux_carry_ff, overflow_ff}, 8'h03);
      go(11'h00b, 4);
      chk(accum_ff, 8'h03);
      go(11'h00c, 4);
      chk({accum_ff[7:1], carry_ff}, 8'h41);
      go(11'h00e, 8);
      chk(accum_ff, 8'h81);
      go(11'h00f, 4);
      chk(accum_ff, 8'h04);
      go(11'h012, 12);
      chk(i_mem.data_mem[8'h21], 8'h02);
      chk(i_mem.data_mem[8'h22], 8'h1b);
      go(11'h014, 8);
      chk(i_mem.data_mem[8'h23], 8'h1b);
      go(11'h016, 12);
      chk(i_mem.data_mem[8'h24], 8'hef);
      chk(table_high_ff, 8'hbe);
      go(11'h017, 4);
      repeat (8) @(posedge clk);
      #1;
      chk({7'h0, halted_ff}, 8'h01);
      chk(8'(wdt_n), 8'h01);
      wake_pin = 1'b1;
      go(11'h019, -1);
      chk({halted_ff, accum_ff[6:0]}, 8'h77);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      wake_pin = 1'b0;
      t_call_return();
      t_skips();
      t_pc_low();
      t_datapath();
      report_and_stop();
   end

   // all four programs finish well inside a few hundred instruction cycles
   initial
   begin
      #(25 * 20000);
      miscompares++;
      report_and_stop();
   end
endmodule
